// >>> rtl/spw_pkg.sv
// Package of constants and types for the servo position window supervisor
package spw_pkg;

  localparam int APB_AW = 8;
  localparam int HALF_W = 16;
  localparam int POS_W  = 32;
  localparam int CODE_W = 8;

  // Half register index: bit 0 selects upper, bits 2:1 select the pair
  localparam int PAIR_POS_PLUS  = 0;
  localparam int PAIR_POS_MINUS = 1;
  localparam int PAIR_LIM_PLUS  = 2;
  localparam int PAIR_LIM_MINUS = 3;
  localparam int NUM_PAIRS      = 4;

  localparam logic [APB_AW-1:0] OFS_HALF_BASE   = 8'h00;
  localparam logic [APB_AW-1:0] OFS_HALF_LAST   = 8'h1c;
  localparam logic [APB_AW-1:0] OFS_ROUGH_RANGE = 8'h20;
  localparam logic [APB_AW-1:0] OFS_S_TIME      = 8'h24;
  localparam logic [APB_AW-1:0] OFS_HIST_CLEAR  = 8'h28;
  localparam logic [APB_AW-1:0] OFS_STATUS      = 8'h2c;
  localparam logic [APB_AW-1:0] OFS_IRQ_STAT    = 8'h30;
  localparam logic [APB_AW-1:0] OFS_IRQ_MASK    = 8'h34;
  localparam logic [APB_AW-1:0] OFS_HIST_COUNT  = 8'h38;
  localparam logic [APB_AW-1:0] OFS_HIST_BASE   = 8'h40;
  localparam logic [APB_AW-1:0] OFS_HIST_LAST   = 8'h54;

  // Three decimal digits per half
  localparam int              HALF_SCALE = 1000;
  localparam logic signed [HALF_W-1:0] HALF_MAX = 16'sh03e7;
  localparam logic signed [HALF_W-1:0] HALF_MIN = -16'sh03e7;

  localparam int              HIST_DEPTH = 6;
  localparam int              HIST_IDX_W = 3;
  localparam logic [CODE_W-1:0] ALARM_PARAM_ERR = 8'h37;

  localparam logic [HALF_W-1:0] HALF_RESET   = 16'h0000;
  localparam logic [15:0]       ROUGH_RESET  = 16'h0000;
  localparam logic [15:0]       S_TIME_RESET = 16'h0000;

  // Irq status and mask bit positions
  localparam int IRQ_PARAM_ERR = 0;
  localparam int IRQ_LIMIT     = 1;
  localparam int IRQ_ALARM     = 2;
  localparam int IRQ_W         = 3;

  // Millisecond time base for the S-pattern constant
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [APB_AW-1:0] paddr;
    logic              pwrite;
    logic [31:0]       pwdata;
  } spw_apb_req_s;

  typedef struct packed {
    logic soft_limit_active;
    logic param_err;
    logic limit_stop;
    logic pos_complete;
    logic rough_match;
    logic pos_range;
  } spw_status_s;

endpackage

// >>> rtl/spw_half_pair.sv
// One signed address formed from a lower and an upper three-digit half
`timescale 1ns/1ps
module spw_half_pair
  import spw_pkg::*;
(
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Half writes
  input  wire logic                    wr_lo,
  input  wire logic                    wr_hi,
  input  wire logic [HALF_W-1:0]       wdata,
  // Readback and result
  output logic      [HALF_W-1:0]       lo_q,
  output logic      [HALF_W-1:0]       hi_q,
  output logic signed [POS_W-1:0]      value,
  output logic                         half_err
);

  logic [HALF_W-1:0] lo_pend_reg;
  logic [HALF_W-1:0] lo_reg;
  logic [HALF_W-1:0] hi_reg;

  // Lower half waits until the upper arrives, so no torn value is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_pend_reg <= HALF_RESET;
      lo_reg      <= HALF_RESET;
      hi_reg      <= HALF_RESET;
    end else begin
      if (wr_lo) begin
        lo_pend_reg <= wdata;
      end
      if (wr_hi) begin
        hi_reg <= wdata;
        lo_reg <= lo_pend_reg;
      end
    end
  end

  wire logic signed [HALF_W-1:0] lo_s = signed'(lo_reg);
  wire logic signed [HALF_W-1:0] hi_s = signed'(hi_reg);
  wire logic signed [POS_W-1:0]  lo_ext = POS_W'(lo_s);
  wire logic signed [POS_W-1:0]  hi_ext = POS_W'(hi_s);
  wire logic lo_neg  = lo_s < 0;
  wire logic lo_pos  = lo_s > 0;
  wire logic hi_neg  = hi_s < 0;
  wire logic hi_pos  = hi_s > 0;
  wire logic sign_mm = (lo_neg & hi_pos) | (lo_pos & hi_neg);
  wire logic out_rng = (lo_s > HALF_MAX) | (lo_s < HALF_MIN) |
                       (hi_s > HALF_MAX) | (hi_s < HALF_MIN);

  assign value    = POS_W'(hi_ext * HALF_SCALE) + lo_ext;
  assign half_err = sign_mm | out_rng;
  assign lo_q     = lo_pend_reg;
  assign hi_q     = hi_reg;

endmodule

// >>> rtl/spw_alarm_hist.sv
// Alarm history: current alarm plus earlier ones, kept across presetn
`timescale 1ns/1ps
module spw_alarm_hist
  import spw_pkg::*;
(
  // Clock and power-on reset
  input  wire logic                  pclk,
  input  wire logic                  por_n,
  // Update
  input  wire logic                  push,
  input  wire logic [CODE_W-1:0]     push_code,
  input  wire logic                  clear,
  // Read
  input  wire logic [HIST_IDX_W-1:0] rd_idx,
  output logic      [CODE_W-1:0]     rd_data,
  output logic      [HIST_IDX_W-1:0] count
);

  logic [CODE_W-1:0]     entry_reg [HIST_DEPTH];
  logic [HIST_IDX_W-1:0] count_reg;
  logic [CODE_W-1:0]     rd_data_reg;

  // Entry 0 is the current alarm; older ones shift down and fall off
  genvar gi;
  generate
    for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_entry
      always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
          entry_reg[gi] <= '0;
        end else if (clear) begin
          entry_reg[gi] <= '0;
        end else if (push) begin
          // Index clamped so entry 0 never names a slot below the array
          entry_reg[gi] <= (gi == 0) ? push_code :
                           entry_reg[(gi > 0) ? gi - 1 : 0];
        end
      end
    end
  endgenerate

  wire logic full = count_reg == HIST_IDX_W'(HIST_DEPTH);

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      count_reg   <= '0;
      rd_data_reg <= '0;
    end else begin
      if (clear) begin
        count_reg <= '0;
      end else if (push && !full) begin
        count_reg <= count_reg + 1'b1;
      end
      rd_data_reg <= (rd_idx < HIST_IDX_W'(HIST_DEPTH)) ?
                     entry_reg[rd_idx] : '0;
    end
  end

  assign rd_data = rd_data_reg;
  assign count   = count_reg;

endmodule

// >>> rtl/spw_top.sv
// Position window, rough match, soft limit and alarm history supervisor
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module spw_top
  import spw_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
  // Clock and resets
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    hist_por_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [APB_AW-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Motion core
  input  wire logic signed [POS_W-1:0] cur_pos,
  input  wire logic [POS_W-1:0]        remaining_dist,
  input  wire logic                    in_position_raw,
  input  wire logic                    homing_active,
  input  wire logic                    alarm_valid,
  input  wire logic [CODE_W-1:0]       alarm_code,
  // Stored history clear setting
  input  wire logic                    hist_clear_boot,
  output logic                         hist_clear_setting,
  // Outputs
  output logic                         position_range_output,
  output logic                         rough_match_output,
  output logic                         positioning_complete_output,
  output logic                         motor_stop,
  output logic                         servo_lock,
  output logic                         parameter_error_alarm,
  output logic                         irq
);

  spw_apb_req_s req;
  assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};

  // APB decode; one wait state so read data comes from a flop
  logic ack_reg;
  logic [31:0] prdata_reg;

  wire logic access   = psel & penable;
  wire logic done     = access & ack_reg;
  wire logic wr_en    = done & req.pwrite;
  wire logic in_half  = req.paddr <= OFS_HALF_LAST;
  wire logic in_hist  = (req.paddr >= OFS_HIST_BASE) &&
                        (req.paddr <= OFS_HIST_LAST);
  wire logic sel_rough = req.paddr == OFS_ROUGH_RANGE;
  wire logic sel_stime = req.paddr == OFS_S_TIME;
  wire logic sel_hclr  = req.paddr == OFS_HIST_CLEAR;
  wire logic sel_stat  = req.paddr == OFS_STATUS;
  wire logic sel_istat = req.paddr == OFS_IRQ_STAT;
  wire logic sel_imask = req.paddr == OFS_IRQ_MASK;
  wire logic sel_hcnt  = req.paddr == OFS_HIST_COUNT;
  wire logic aligned   = req.paddr[1:0] == 2'h0;
  wire logic addr_hit  = aligned & (in_half | in_hist | sel_rough |
                         sel_stime | sel_hclr | sel_stat | sel_istat |
                         sel_imask | sel_hcnt);
  wire logic [2:0] half_idx = req.paddr[4:2];
  wire logic [HIST_IDX_W-1:0] hist_idx =
    HIST_IDX_W'((req.paddr - OFS_HIST_BASE) >> 2);

  // Half registers: four signed pairs
  logic [HALF_W-1:0]       lo_q   [NUM_PAIRS];
  logic [HALF_W-1:0]       hi_q   [NUM_PAIRS];
  logic signed [POS_W-1:0] pval   [NUM_PAIRS];
  logic [NUM_PAIRS-1:0]    herr;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_pair
      wire logic pick = wr_en & aligned & in_half &
                        (half_idx[2:1] == 2'(gp));
      spw_half_pair u_pair (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_lo    (pick & ~half_idx[0]),
        .wr_hi    (pick & half_idx[0]),
        .wdata    (req.pwdata[HALF_W-1:0]),
        .lo_q     (lo_q[gp]),
        .hi_q     (hi_q[gp]),
        .value    (pval[gp]),
        .half_err (herr[gp])
      );
    end
  endgenerate

  wire logic [HALF_W-1:0] pos_range_minus_lower_half = lo_q[PAIR_POS_MINUS];
  wire logic [HALF_W-1:0] pos_range_minus_upper_half = hi_q[PAIR_POS_MINUS];
  wire logic [HALF_W-1:0] half_rd = half_idx[0] ? hi_q[half_idx[2:1]] :
                                                  lo_q[half_idx[2:1]];

  wire logic signed [POS_W-1:0] win_hi = pval[PAIR_POS_PLUS];
  wire logic signed [POS_W-1:0] win_lo = pval[PAIR_POS_MINUS];
  wire logic signed [POS_W-1:0] lim_hi = pval[PAIR_LIM_PLUS];
  wire logic signed [POS_W-1:0] lim_lo = pval[PAIR_LIM_MINUS];

  // Control registers
  logic [15:0]       rough_range_reg;
  logic [15:0]       s_time_reg;
  logic              hist_clear_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic [IRQ_W-1:0]  irq_event;

  // Parameter error: halves of mixed sign or out of range, or inverted soft limits
  wire logic lim_inverted = lim_hi < lim_lo;
  wire logic perr_now     = (|herr) | lim_inverted;
  logic perr_reg;
  wire logic perr_rise    = perr_now & ~perr_reg;

  // Soft limit check
  wire logic lim_enabled  = (lim_hi != lim_lo) & ~homing_active;
  wire logic beyond       = (cur_pos > lim_hi) | (cur_pos < lim_lo);
  logic limit_reg;
  wire logic limit_next   = lim_enabled & ~perr_now & beyond;
  wire logic limit_rise   = limit_next & ~limit_reg;

  // Window and rough match
  logic range_reg;
  logic rough_reg;
  wire logic in_window = (cur_pos >= win_lo) & (cur_pos <= win_hi);
  wire logic rough_hit = remaining_dist <= POS_W'(rough_range_reg);

  // Positioning complete held back by the S-pattern time
  logic [31:0] tick_reg;
  logic [15:0] ms_reg;
  logic        cmpl_reg;
  wire logic tick_wrap = tick_reg == 32'(MS_CYCLES - 1);
  wire logic s_elapsed = ms_reg == s_time_reg;

  // History clear setting captured after presetn release, then acted on once
  logic       boot_meta_reg;
  logic       boot_sync_reg;
  logic [1:0] boot_cnt_reg;
  logic       boot_done_reg;
  wire logic  boot_take  = (boot_cnt_reg == 2'h3) & ~boot_done_reg;
  wire logic  hist_clear = boot_take & boot_sync_reg;

  // Alarm history; own parameter error takes the slot if both arrive
  logic [CODE_W-1:0]     hist_rd;
  logic [HIST_IDX_W-1:0] hist_cnt;
  wire logic hist_push = perr_rise | alarm_valid;
  wire logic [CODE_W-1:0] push_code = perr_rise ? ALARM_PARAM_ERR :
                                                  alarm_code;

  spw_alarm_hist u_hist (
    .pclk      (pclk),
    .por_n     (hist_por_n),
    .push      (hist_push),
    .push_code (push_code),
    .clear     (hist_clear),
    .rd_idx    (hist_idx),
    .rd_data   (hist_rd),
    .count     (hist_cnt)
  );

  spw_status_s status;
  assign status = '{soft_limit_active: lim_enabled, param_err: perr_reg,
                    limit_stop: limit_reg, pos_complete: cmpl_reg,
                    rough_match: rough_reg, pos_range: range_reg};

  assign irq_event = {hist_push, limit_rise, perr_rise};

  wire logic [31:0] rd_mux =
    !addr_hit ? 32'h0 :
    in_half   ? 32'(half_rd) :
    in_hist   ? 32'(hist_rd) :
    sel_rough ? 32'(rough_range_reg) :
    sel_stime ? 32'(s_time_reg) :
    sel_hclr  ? 32'(hist_clear_reg) :
    sel_stat  ? 32'(status) :
    sel_istat ? 32'(irq_stat_reg) :
    sel_imask ? 32'(irq_mask_reg) :
                32'(hist_cnt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg    <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (access && !ack_reg) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rough_range_reg <= ROUGH_RESET;
      s_time_reg      <= S_TIME_RESET;
      irq_mask_reg    <= '0;
      irq_stat_reg    <= '0;
    end else begin
      if (wr_en && sel_rough) rough_range_reg <= req.pwdata[15:0];
      if (wr_en && sel_stime) s_time_reg <= req.pwdata[15:0];
      if (wr_en && sel_imask) irq_mask_reg <= req.pwdata[IRQ_W-1:0];
      // A new event wins over a write-one-to-clear in the same cycle
      irq_stat_reg <= (irq_stat_reg &
                       ~({IRQ_W{wr_en & sel_istat}} &
                         req.pwdata[IRQ_W-1:0])) | irq_event;
    end
  end

  // Setting is stored only; it returns to zero once the clear is done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_clear_reg <= 1'b0;
      boot_meta_reg  <= 1'b0;
      boot_sync_reg  <= 1'b0;
      boot_cnt_reg   <= 2'h0;
      boot_done_reg  <= 1'b0;
    end else begin
      boot_meta_reg <= hist_clear_boot;
      boot_sync_reg <= boot_meta_reg;
      if (boot_cnt_reg != 2'h3) boot_cnt_reg <= boot_cnt_reg + 2'h1;
      if (boot_take) boot_done_reg <= 1'b1;
      if (hist_clear) begin
        hist_clear_reg <= 1'b0;
      end else if (boot_take) begin
        hist_clear_reg <= boot_sync_reg;
      end else if (wr_en && sel_hclr) begin
        hist_clear_reg <= req.pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_reg  <= 1'b0;
      limit_reg <= 1'b0;
      range_reg <= 1'b0;
      rough_reg <= 1'b0;
    end else begin
      perr_reg  <= perr_now;
      limit_reg <= limit_next;
      range_reg <= in_window;
      rough_reg <= rough_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 32'h0;
      ms_reg   <= 16'h0;
      cmpl_reg <= 1'b0;
    end else if (!in_position_raw) begin
      tick_reg <= 32'h0;
      ms_reg   <= 16'h0;
      cmpl_reg <= 1'b0;
    end else if (s_elapsed) begin
      cmpl_reg <= 1'b1;
    end else if (tick_wrap) begin
      tick_reg <= 32'h0;
      ms_reg   <= ms_reg + 16'h1;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end

  assign prdata                      = prdata_reg;
  assign pready                      = done;
  assign pslverr                     = done & ~addr_hit;
  assign hist_clear_setting          = hist_clear_reg;
  assign position_range_output       = range_reg;
  assign rough_match_output          = rough_reg;
  assign positioning_complete_output = cmpl_reg;
  assign motor_stop                  = limit_reg;
  assign servo_lock                  = limit_reg;
  assign parameter_error_alarm       = perr_reg;
  assign irq                         = |(irq_stat_reg & irq_mask_reg);

endmodule

// >>> verification/spw_host_model.sv
// APB host model that writes and reads supervisor parameters
`timescale 1ns/1ps
module spw_host_model
  import spw_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB master
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic [APB_AW-1:0]      paddr,
  output logic [31:0]            pwdata,
  input  wire logic              pready,
  // Set when a slave never answers
  output logic                   hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    hung = 1'b0;
  end

  // One idle edge first, so a release never meets the next setup
  task automatic xfer(input logic w, input logic [APB_AW-1:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hung <= 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Truncating division keeps both halves on the sign of the value
  task automatic wpair(input int pair, input int val);
    int lo;
    int hi;
    lo = val % HALF_SCALE;
    hi = val / HALF_SCALE;
    xfer(1'b1, 8'(8 * pair), {16'h0, 16'(lo)});
    xfer(1'b1, 8'(8 * pair + 4), {16'h0, 16'(hi)});
  endtask
endmodule

// >>> verification/spw_top_chk.sv
// Port-level assertions for the position window supervisor
`timescale 1ns/1ps
module spw_top_chk
  import spw_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [APB_AW-1:0]       paddr,
  input wire logic                    pready,
  input wire logic signed [POS_W-1:0] cur_pos,
  input wire logic [POS_W-1:0]        remaining_dist,
  input wire logic                    in_position_raw,
  input wire logic                    homing_active,
  input wire logic                    hist_clear_setting,
  input wire logic                    position_range_output,
  input wire logic                    rough_match_output,
  input wire logic                    positioning_complete_output,
  input wire logic                    motor_stop,
  input wire logic                    servo_lock,
  input wire logic                    parameter_error_alarm
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LOCK: assert property (servo_lock == motor_stop)
    else $error("servo lock differs from motor stop");
  AST_HOMING: assert property (homing_active |=> !motor_stop)
    else $error("limit stop during home return");
  AST_PERR: assert property (parameter_error_alarm |-> !motor_stop)
    else $error("limit stop with parameter error");
  AST_PC_FALL: assert property (
    !in_position_raw |=> !positioning_complete_output)
    else $error("complete without raw in-position");
  AST_PC_RISE: assert property (
    $rose(positioning_complete_output) |-> $past(in_position_raw))
    else $error("complete rose without raw in-position");
  // The release edge still clocks the reset branch, so it starts no attempt
  AST_ROUGH: assert property (
    presetn && remaining_dist == '0 |=> rough_match_output)
    else $error("no rough match at zero distance");
  AST_RANGE: assert property (
    (presetn && !psel && $stable(cur_pos)) [*3] |->
    $stable(position_range_output))
    else $error("range output moved with steady position");
  AST_CLEAR: assert property ($rose(hist_clear_setting) |->
    $past(psel && penable && pwrite && pready && paddr == OFS_HIST_CLEAR))
    else $error("clear setting rose without a write");
endmodule

bind spw_top spw_top_chk #(.MS_CYCLES(MS_CYCLES)) u_spw_top_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .cur_pos,
  .remaining_dist, .in_position_raw, .homing_active, .hist_clear_setting,
  .position_range_output, .rough_match_output, .positioning_complete_output,
  .motor_stop, .servo_lock, .parameter_error_alarm
);

// >>> verification/tb_spw_top.sv
// Self-checking testbench for the position window supervisor
`timescale 1ns/1ps
module tb_spw_top
  import spw_pkg::*;
;
  typedef struct packed {
    logic [APB_AW-1:0] a;
    logic [31:0]       d;
    logic              e;
  } spw_note_s;
  localparam int EDGE_POS [4] = '{-2002, -2001, 123456, 123457};

  logic pclk = 1'b0, presetn = 1'b0, hist_por_n = 1'b0, hist_clear_boot = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, hung, hist_clear_setting;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic signed [POS_W-1:0] cur_pos = '0;
  logic [POS_W-1:0] remaining_dist = '0;
  logic in_position_raw = 1'b0, homing_active = 1'b0, alarm_valid = 1'b0;
  logic [CODE_W-1:0] alarm_code = '0;
  logic position_range_output, rough_match_output, positioning_complete_output;
  logic motor_stop, servo_lock, parameter_error_alarm, irq;
  logic [31:0] seed = 32'h0000_0f53;
  spw_note_s exp_q [$];
  spw_note_s note;
  int n_fail = 0;
  int n_tests = 0;

  always #5 pclk = ~pclk;

  spw_top #(.MS_CYCLES(4)) u_spw_top (.pclk, .presetn, .hist_por_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cur_pos,
    .remaining_dist, .in_position_raw, .homing_active, .alarm_valid,
    .alarm_code, .hist_clear_boot, .hist_clear_setting, .position_range_output,
    .rough_match_output, .positioning_complete_output, .motor_stop,
    .servo_lock, .parameter_error_alarm, .irq);
  spw_host_model u_spw_host_model (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .hung);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] d,
                    input logic e = 1'b0);
    exp_q.push_back('{a, d, e});
    u_spw_host_model.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    u_spw_host_model.xfer(1'b1, a, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic finish_test();
    cmp("read queue left", 32'h0, 32'(exp_q.size()));
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Read results are matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) cmp("read queue", 32'h1, 32'h0);
      else begin
        note = exp_q.pop_front();
        cmp($sformatf("prdata %h", note.a), note.d, prdata);
        cmp($sformatf("pslverr %h", note.a), 32'(note.e), 32'(pslverr));
      end
    end
  end

  initial begin
    for (int k = 0; k < 90000 && hung !== 1'b1; k++) @(posedge pclk);
    n_fail++;
    finish_test();
  end

  initial begin
    int p;
    int r;
    int i;
    tick(6);
    presetn <= 1'b1;
    hist_por_n <= 1'b1;
    for (i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
    rd(OFS_HIST_COUNT, 32'h0);
    rd(8'h3c, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    u_spw_host_model.wpair(PAIR_POS_PLUS, 123456);
    u_spw_host_model.wpair(PAIR_POS_MINUS, -2001);
    wr(OFS_ROUGH_RANGE, 32'h32);
    rd(8'h08, 32'h0000_ffff);
    rd(8'h0c, 32'h0000_fffe);
    for (i = 0; i < 12; i++) begin
      p = (i < 4) ? EDGE_POS[i] : int'(xs() % 32'h1_fbd0) - 4000;
      r = int'(xs() % 32'h64);
      @(posedge pclk);
      cur_pos <= p;
      remaining_dist <= r;
      rd(OFS_STATUS,
         {30'h0, r <= 50, p >= -2001 && p <= 123456});
    end
    u_spw_host_model.wpair(PAIR_LIM_PLUS, 5000);
    u_spw_host_model.wpair(PAIR_LIM_MINUS, -5000);
    @(posedge pclk);
    cur_pos <= 6000;
    remaining_dist <= '0;
    rd(OFS_STATUS, 32'h2b);
    cmp("servo_lock", 32'h1, 32'(servo_lock));
    @(posedge pclk);
    homing_active <= 1'b1;
    rd(OFS_STATUS, 32'h03);
    @(posedge pclk);
    homing_active <= 1'b0;
    wr(OFS_IRQ_MASK, 32'h1);
    u_spw_host_model.wpair(PAIR_LIM_PLUS, -6000);
    rd(OFS_STATUS, 32'h33);
    cmp("irq", 32'h1, 32'(irq));
    rd(OFS_HIST_BASE, 32'h37);
    wr(OFS_IRQ_STAT, 32'h7);
    tick(2);
    cmp("irq", 32'h0, 32'(irq));
    for (i = 1; i <= 6; i++) begin
      @(posedge pclk);
      alarm_valid <= 1'b1;
      alarm_code <= 8'(i);
    end
    @(posedge pclk);
    alarm_valid <= 1'b0;
    for (i = 0; i < 6; i++) rd(8'(OFS_HIST_BASE + 4 * i), 32'(6 - i));
    rd(OFS_HIST_COUNT, 32'h6);
    cmp("irq", 32'h0, 32'(irq));
    u_spw_host_model.wpair(PAIR_LIM_PLUS, 5000);
    wr(8'h08, 32'h5);
    wr(8'h0c, 32'hfffe);
    rd(OFS_STATUS, 32'h33);
    rd(OFS_HIST_BASE, 32'h37);
    u_spw_host_model.wpair(PAIR_POS_MINUS, -2001);
    wr(OFS_S_TIME, 32'h2);
    @(posedge pclk);
    in_position_raw <= 1'b1;
    tick(7);
    #1 cmp("complete", 32'h0, 32'(positioning_complete_output));
    tick(5);
    #1 cmp("complete", 32'h1, 32'(positioning_complete_output));
    @(posedge pclk);
    in_position_raw <= 1'b0;
    wr(OFS_HIST_CLEAR, 32'h1);
    tick(2);
    cmp("clear setting", 32'h1, 32'(hist_clear_setting));
    rd(OFS_HIST_COUNT, 32'h6);
    @(posedge pclk);
    presetn <= 1'b0;
    hist_clear_boot <= 1'b1;
    tick(3);
    presetn <= 1'b1;
    tick(8);
    cmp("clear setting", 32'h0, 32'(hist_clear_setting));
    rd(OFS_HIST_COUNT, 32'h0);
    // Let the read monitor take the last answer before the verdict
    tick(2);
    finish_test();
  end
endmodule
